// ===== rtl/pmic_serial_control_regs.sv
`timescale 1ns/100ps
`include "pmic_regs_cfg.svh"
module pmic_serial_control_regs #(
  parameter int unsigned DLY_SHORT = `DLY_SHORT_CYC,
  parameter int unsigned DLY_LONG  = `DLY_LONG_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic                   serial_clk_pin,
  input  wire logic                   serial_data_pin_in,
  output logic                        serial_data_pin_out,
  output logic                        serial_data_pin_oe_n,
  input  wire logic                   oscillator_enable_pin,
  input  wire logic                   outputs_in_range,
  output pmic_regs_pkg::ctrl_out_t    ctrl,
  output logic                        pulse_freq_mode,
  output logic                        fault_flag
);
  logic [7:0] osc_adj;
  logic [7:0] linear_aux;
  logic [7:0] conv_run;
  logic [7:0] conv_sleep;
  logic [7:0] rd_data;
  logic [7:0] index;
  logic [7:0] shift;
  logic [`BIT_CNT_W-1:0] bit_cnt;
  logic       scl_q;
  logic       sda_q;
  logic       is_read;
  logic       have_index;
  logic       wr_en;
  logic       start_seen;
  logic       stop_seen;
  logic       scl_rise;
  logic       scl_fall;
  logic [`DLY_CNT_W-1:0] dly_cnt;
  logic [`DLY_CNT_W-1:0] dly_target;
  pmic_regs_pkg::serial_state_t state;

  pmic_reg_store u_store (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .clk_en     (clk_en),
    .wr_en      (wr_en),
    .index      (index),
    .wr_data    (shift),
    .rd_data    (rd_data),
    .osc_adj    (osc_adj),
    .linear_aux (linear_aux),
    .conv_run   (conv_run),
    .conv_sleep (conv_sleep)
  );

  // pins are taken as synchronous, so one stage only serves edge detection
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_q <= serial_clk_pin;
      sda_q <= serial_data_pin_in;
    end
  end

  assign scl_rise   = serial_clk_pin & ~scl_q;
  assign scl_fall   = ~serial_clk_pin & scl_q;
  assign start_seen = serial_clk_pin & scl_q & sda_q & ~serial_data_pin_in;
  assign stop_seen  = serial_clk_pin & scl_q & ~sda_q & serial_data_pin_in;
  assign wr_en      = clk_en && state == pmic_regs_pkg::ST_WACK && scl_fall
                      && have_index && !serial_data_pin_oe_n;

  // bus protocol engine
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state      <= pmic_regs_pkg::ST_IDLE;
      shift      <= 8'h00;
      bit_cnt    <= '0;
      is_read    <= 1'b0;
      have_index <= 1'b0;
      index      <= 8'h00;
    end else if (clk_en) begin
      if (start_seen) begin
        // repeated start keeps the index for the read that follows
        state   <= pmic_regs_pkg::ST_ADDR;
        bit_cnt <= '0;
      end else if (stop_seen) begin
        state <= pmic_regs_pkg::ST_IDLE;
      end else begin
        case (state)
          pmic_regs_pkg::ST_IDLE: ;
          pmic_regs_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], serial_data_pin_in};
              bit_cnt <= bit_cnt + 1'b1;
            end
            if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
              bit_cnt <= '0;
              if (shift[7:1] == `SLAVE_ADDR) begin
                is_read    <= shift[0];
                have_index <= 1'b0;
                state      <= pmic_regs_pkg::ST_AACK;
              end else begin
                state <= pmic_regs_pkg::ST_IDLE;
              end
            end
          end
          pmic_regs_pkg::ST_AACK: begin
            if (scl_fall) begin
              state <= is_read ? pmic_regs_pkg::ST_RBYTE : pmic_regs_pkg::ST_WBYTE;
            end
          end
          pmic_regs_pkg::ST_WBYTE: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], serial_data_pin_in};
              bit_cnt <= bit_cnt + 1'b1;
            end
            if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
              bit_cnt <= '0;
              state   <= pmic_regs_pkg::ST_WACK;
            end
          end
          pmic_regs_pkg::ST_WACK: begin
            if (scl_fall) begin
              // first byte is the index, later bytes are data with auto-increment
              if (!have_index) begin
                index      <= shift;
                have_index <= 1'b1;
              end else begin
                index <= index + 8'h01;
              end
              state <= pmic_regs_pkg::ST_WBYTE;
            end
          end
          pmic_regs_pkg::ST_RBYTE: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == `BITS_PER_BYTE - 4'h1) begin
                bit_cnt <= '0;
                state   <= pmic_regs_pkg::ST_RACK;
              end
            end
          end
          pmic_regs_pkg::ST_RACK: begin
            if (scl_rise) begin
              // master nack ends the read
              is_read <= ~serial_data_pin_in;
            end
            if (scl_fall) begin
              index <= index + 8'h01;
              state <= is_read ? pmic_regs_pkg::ST_RBYTE : pmic_regs_pkg::ST_IDLE;
            end
          end
          default: state <= pmic_regs_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // data pin driver: low enable pulls low; ack or read data bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serial_data_pin_out  <= 1'b0;
      serial_data_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      serial_data_pin_out <= 1'b0;
      case (state)
        pmic_regs_pkg::ST_AACK,
        pmic_regs_pkg::ST_WACK: serial_data_pin_oe_n <= 1'b0;
        pmic_regs_pkg::ST_RBYTE:
          serial_data_pin_oe_n <= rd_data[3'h7 - bit_cnt[2:0]];
        default: serial_data_pin_oe_n <= 1'b1;
      endcase
    end
  end

  // control outputs; pin overrides act after the register bits
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl.aux_switch_disable      <= 1'(`RST_LINEAR_AUX >> `BIT_HI);
      ctrl.oscillator_on           <= 1'(`RST_CONV_RUN >> `BIT_HI);
      ctrl.converter_enable        <= 1'(`RST_CONV_RUN >> `BIT_MID);
      ctrl.fault_flag_delay_select <= 1'(`RST_CONV_SLEEP >> `BIT_HI);
      ctrl.converter_slew_select   <= 1'(`RST_CONV_SLEEP >> `BIT_MID);
      ctrl.linear_reg_voltage_code <= 6'(`RST_LINEAR_AUX);
      ctrl.converter_code          <= 6'(`RST_CONV_RUN);
      ctrl.oscillator_adjust_value <= `RST_OSC_ADJ;
      pulse_freq_mode              <= 1'b0;
    end else if (clk_en) begin
      ctrl.aux_switch_disable      <= linear_aux[`BIT_HI] | ~oscillator_enable_pin;
      ctrl.linear_reg_voltage_code <= linear_aux[`CODE_MSB:0];
      ctrl.oscillator_on           <= conv_run[`BIT_HI];
      ctrl.converter_enable        <= conv_run[`BIT_MID];
      ctrl.fault_flag_delay_select <= conv_sleep[`BIT_HI];
      ctrl.converter_slew_select   <= conv_sleep[`BIT_MID];
      ctrl.converter_code          <= oscillator_enable_pin ? conv_run[`CODE_MSB:0]
                                      : conv_sleep[`CODE_MSB:0];
      ctrl.oscillator_adjust_value <= osc_adj;
      pulse_freq_mode              <= ~oscillator_enable_pin;
    end
  end

  assign dly_target = conv_sleep[`BIT_HI] ? `DLY_CNT_W'(DLY_LONG) : `DLY_CNT_W'(DLY_SHORT);

  // fault flag release delay; any drop restarts the wait
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dly_cnt    <= '0;
      fault_flag <= 1'b0;
    end else if (clk_en) begin
      if (!outputs_in_range || !conv_run[`BIT_MID]) begin
        dly_cnt    <= '0;
        fault_flag <= 1'b0;
      end else if (dly_cnt < dly_target) begin
        dly_cnt <= dly_cnt + 1'b1;
      end else begin
        fault_flag <= 1'b1;
      end
    end
  end

  fault_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && !outputs_in_range) |=> !fault_flag) else $error("fault flag high while out of range");
  aux_forced_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && !oscillator_enable_pin) |=> ctrl.aux_switch_disable) else $error("aux not forced off");
  sleep_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && !oscillator_enable_pin) |=> (ctrl.converter_code == $past(conv_sleep[5:0]) && pulse_freq_mode))
    else $error("sleep code not selected");
  run_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clk_en && oscillator_enable_pin) |=> ctrl.converter_code == $past(conv_run[5:0]))
    else $error("run code not selected");
  addr_match_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == pmic_regs_pkg::ST_AACK) |-> ($past(shift[7:1]) == `SLAVE_ADDR || $past(state) == state))
    else $error("ack without address match");
  osc_bits_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> (ctrl.oscillator_on == $past(conv_run[7]) && ctrl.converter_enable == $past(conv_run[6])))
    else $error("oscillator or converter bit wrong");
  delay_bits_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> (ctrl.fault_flag_delay_select == $past(conv_sleep[7]) && ctrl.converter_slew_select == $past(conv_sleep[6])))
    else $error("delay or slew bit wrong");
  trim_copy_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> ctrl.oscillator_adjust_value == $past(osc_adj)) else $error("trim value wrong");
  linear_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> ctrl.linear_reg_voltage_code == $past(linear_aux[5:0])) else $error("linear code wrong");
endmodule : pmic_serial_control_regs

// ===== common/pmic_regs_cfg.svh
`ifndef PMIC_REGS_CFG_SVH
`define PMIC_REGS_CFG_SVH
`define SLAVE_ADDR        7'h6C
`define REG_OSC_ADJ       8'h00
`define REG_LINEAR_AUX    8'h01
`define REG_CONV_RUN      8'h02
`define REG_CONV_SLEEP    8'h03
`define RST_OSC_ADJ       8'h00
`define RST_LINEAR_AUX    8'hD2
`define RST_CONV_RUN      8'hCF
`define RST_CONV_SLEEP    8'h0F
`define BIT_HI            7
`define BIT_MID           6
`define CODE_MSB          5
`define CLK_HZ            10000000
`define DLY_SHORT_US      1070
`define DLY_LONG_US       8400
`define DLY_SHORT_CYC     ((`DLY_SHORT_US * (`CLK_HZ / 1000)) / 1000)
`define DLY_LONG_CYC      ((`DLY_LONG_US * (`CLK_HZ / 1000)) / 1000)
`define DLY_CNT_W         17
`define BIT_CNT_W         4
`define BITS_PER_BYTE     4'h8
`endif

// ===== common/pmic_regs_pkg.sv
package pmic_regs_pkg;
  typedef struct packed {
    logic       aux_switch_disable;
    logic       oscillator_on;
    logic       converter_enable;
    logic       fault_flag_delay_select;
    logic       converter_slew_select;
    logic [5:0] linear_reg_voltage_code;
    logic [5:0] converter_code;
    logic [7:0] oscillator_adjust_value;
  } ctrl_out_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_AACK  = 7'b0000100,
    ST_WBYTE = 7'b0001000,
    ST_WACK  = 7'b0010000,
    ST_RBYTE = 7'b0100000,
    ST_RACK  = 7'b1000000
  } serial_state_t;
endpackage : pmic_regs_pkg

// ===== rtl/pmic_reg_store.sv
`timescale 1ns/100ps
`include "pmic_regs_cfg.svh"
module pmic_reg_store (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [7:0] index,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic      [7:0] osc_adj,
  output logic      [7:0] linear_aux,
  output logic      [7:0] conv_run,
  output logic      [7:0] conv_sleep
);
  // power-up values for all four registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_adj    <= `RST_OSC_ADJ;
      linear_aux <= `RST_LINEAR_AUX;
      conv_run   <= `RST_CONV_RUN;
      conv_sleep <= `RST_CONV_SLEEP;
    end else if (clk_en && wr_en) begin
      case (index)
        `REG_OSC_ADJ:    osc_adj    <= wr_data;
        `REG_LINEAR_AUX: linear_aux <= wr_data;
        `REG_CONV_RUN:   conv_run   <= wr_data;
        `REG_CONV_SLEEP: conv_sleep <= wr_data;
        default: ;
      endcase
    end
  end

  // registered read port; unmapped index reads zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      case (index)
        `REG_OSC_ADJ:    rd_data <= osc_adj;
        `REG_LINEAR_AUX: rd_data <= linear_aux;
        `REG_CONV_RUN:   rd_data <= conv_run;
        `REG_CONV_SLEEP: rd_data <= conv_sleep;
        default:         rd_data <= 8'h00;
      endcase
    end
  end
endmodule : pmic_reg_store

// ===== verification/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model #(
  parameter int unsigned QUARTER = 7
) (
  input  wire logic core_clk,
  input  wire logic dev_oe_n,
  output logic      bus_clk,
  output logic      bus_data
);
  localparam logic [6:0] DEV_ADDR = 7'h6C;
  logic host_pull;
  // pulled up unless someone pulls low, so a released line never keeps a stale bit
  assign bus_data = ~(host_pull | ~dev_oe_n);
  initial begin
    bus_clk   = 1'b1;
    host_pull = 1'b0;
  end
  // four quarters of 7 cycles: 2.8 us a bit, slower than 400 kbit/s
  task automatic quarter;
    repeat (QUARTER) @(negedge core_clk);
  endtask : quarter
  task automatic start;
    host_pull = 1'b0;
    quarter;
    bus_clk = 1'b1;
    quarter;
    host_pull = 1'b1;
    quarter;
    bus_clk = 1'b0;
    quarter;
  endtask : start
  task automatic stop;
    host_pull = 1'b1;
    quarter;
    bus_clk = 1'b1;
    quarter;
    host_pull = 1'b0;
    quarter;
  endtask : stop
  task automatic bit_cycle(input logic drive, output logic seen);
    host_pull = ~drive;
    quarter;
    bus_clk = 1'b1;
    quarter;
    seen = bus_data;
    quarter;
    bus_clk = 1'b0;
    quarter;
  endtask : bit_cycle
  task automatic put_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
    bit_cycle(1'b1, nak);
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
    bit_cycle(last, s);
  endtask : get_byte
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] d, output logic nak);
    logic [2:0] n;
    start;
    put_byte({DEV_ADDR, 1'b0}, n[0]);
    put_byte(idx, n[1]);
    put_byte(d, n[2]);
    stop;
    nak = |n;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic nak);
    logic [2:0] n;
    start;
    put_byte({DEV_ADDR, 1'b0}, n[0]);
    put_byte(idx, n[1]);
    start;
    put_byte({DEV_ADDR, 1'b1}, n[2]);
    get_byte(1'b1, d);
    stop;
    nak = |n;
  endtask : read_reg
endmodule : serial_host_model

// ===== verification/tb_pmic_serial_control_regs.sv
`timescale 1ns/100ps
module tb_pmic_serial_control_regs;
  localparam int unsigned SHORT_DLY = 20;
  localparam int unsigned LONG_DLY  = 50;
  localparam logic [15:0] WR_LIST [5] = '{16'h028F, 16'h023F, 16'h0080, 16'h0176, 16'h03E1};
  logic                     core_clk;
  logic                     nrst;
  logic                     clk_en_in;
  logic                     data_out;
  logic                     osc_pin;
  logic                     in_range;
  logic                     bus_clk;
  logic                     bus_data;
  logic                     data_oe_n;
  logic                     pfm;
  logic                     fault;
  pmic_regs_pkg::ctrl_out_t ctrl;
  logic [7:0]               shadow [4];
  int                       fails;
  int                       checks_done;

  pmic_serial_control_regs #(.DLY_SHORT(SHORT_DLY), .DLY_LONG(LONG_DLY)) DUT (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en_in), .serial_clk_pin(bus_clk),
    .serial_data_pin_in(bus_data), .serial_data_pin_out(data_out), .serial_data_pin_oe_n(data_oe_n),
    .oscillator_enable_pin(osc_pin), .outputs_in_range(in_range), .ctrl(ctrl),
    .pulse_freq_mode(pfm), .fault_flag(fault));
  serial_host_model host (.core_clk(core_clk), .dev_oe_n(data_oe_n), .bus_clk(bus_clk), .bus_data(bus_data));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  function automatic pmic_regs_pkg::ctrl_out_t expected_ctrl();
    pmic_regs_pkg::ctrl_out_t e;
    e.aux_switch_disable      = shadow[1][7] | ~osc_pin;
    e.oscillator_on           = shadow[2][7];
    e.converter_enable        = shadow[2][6];
    e.fault_flag_delay_select = shadow[3][7];
    e.converter_slew_select   = shadow[3][6];
    e.linear_reg_voltage_code = shadow[1][5:0];
    e.converter_code          = osc_pin ? shadow[2][5:0] : shadow[3][5:0];
    e.oscillator_adjust_value = shadow[0];
    return e;
  endfunction : expected_ctrl
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    logic nak;
    host.write_reg(idx, d, nak);
    check(32'(nak), 32'h0);
    if (idx < 8'h04) shadow[idx[1:0]] = d;
  endtask : reg_write
  task automatic reg_expect(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic       nak;
    host.read_reg(idx, d, nak);
    check(32'(nak), 32'h0);
    check(32'(d), 32'(exp));
  endtask : reg_expect
  task automatic check_all;
    check(32'(ctrl), 32'(expected_ctrl()));
    for (int i = 0; i < 4; i++) reg_expect(8'(i), shadow[i]);
  endtask : check_all

  task automatic test_reset_values;
    check(32'({pfm, fault}), 32'h0);
    check(32'(data_out), 32'h0);
    check_all;
  endtask : test_reset_values
  // enable low must hold every output although the pin moves
  task automatic test_freeze;
    pmic_regs_pkg::ctrl_out_t held;
    held      = expected_ctrl();
    clk_en_in = 1'b0;
    osc_pin   = 1'b0;
    repeat (3) @(negedge core_clk);
    check(32'(pfm), 32'h0);
    check(32'(ctrl), 32'(held));
    clk_en_in = 1'b1;
    repeat (3) @(negedge core_clk);
    check(32'(pfm), 32'h1);
    check(32'(ctrl), 32'(expected_ctrl()));
    osc_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    check(32'(ctrl), 32'(expected_ctrl()));
    check(32'(data_out), 32'h0);
  endtask : test_freeze
  task automatic test_writes;
    foreach (WR_LIST[i]) reg_write(WR_LIST[i][15:8], WR_LIST[i][7:0]);
    check_all;
  endtask : test_writes
  task automatic test_refused;
    logic nak;
    host.start;
    host.put_byte({7'h6D, 1'b0}, nak);
    host.stop;
    check(32'(nak), 32'h1);
    reg_write(8'h05, 8'hAA);
    reg_expect(8'h05, 8'h00);
    check_all;
  endtask : test_refused
  task automatic test_sleep_pin;
    osc_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    check(32'(pfm), 32'h1);
    check(32'(ctrl), 32'(expected_ctrl()));
    osc_pin = 1'b1;
    repeat (3) @(negedge core_clk);
    check(32'(pfm), 32'h0);
    check(32'(ctrl), 32'(expected_ctrl()));
  endtask : test_sleep_pin
  task automatic fault_run(input logic [7:0] sleep_val, input int unsigned dly);
    reg_write(8'h03, sleep_val);
    in_range = 1'b1;
    repeat (dly - 2) @(negedge core_clk);
    check(32'(fault), 32'h0);
    repeat (6) @(negedge core_clk);
    check(32'(fault), 32'h1);
    in_range = 1'b0;
    repeat (3) @(negedge core_clk);
    check(32'(fault), 32'h0);
  endtask : fault_run
  task automatic test_fault;
    reg_write(8'h02, 8'hCF);
    fault_run(8'h21, SHORT_DLY);
    fault_run(8'hA1, LONG_DLY);
  endtask : test_fault

  initial begin
    nrst     = 1'b0;
    clk_en_in = 1'b1;
    osc_pin  = 1'b1;
    in_range = 1'b0;
    shadow   = '{8'h00, 8'hD2, 8'hCF, 8'h0F};
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    test_reset_values;
    test_writes;
    test_refused;
    test_sleep_pin;
    test_freeze;
    test_fault;
    test_done;
  end
  // roughly 22000 cycles expected; four times that means a hang
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    test_done;
  end
endmodule : tb_pmic_serial_control_regs
